// ==== include/bbf_pkg.sv ====
package bbf_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam int unsigned AXI_AW     = 8;
  localparam logic [7:0]  OFS_CMD    = 8'h00;
  localparam logic [7:0]  OFS_FLAGS  = 8'h04;
  localparam logic [7:0]  OFS_PC     = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0C;
  localparam logic [7:0]  OFS_SEL    = 8'h10;
  localparam logic [7:0]  OFS_REG    = 8'h14;
  localparam logic [7:0]  OFS_IO     = 8'h18;

  // status_flags_reg bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;

  // command word fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_RD_LSB  = 6;
  localparam int unsigned CMD_BIT_LSB = 11;
  localparam int unsigned CMD_IO_LSB  = 14;
  localparam int unsigned CMD_K_LSB   = 19;
  localparam int unsigned K_W         = 7;

  // status register fields and cycle figures
  localparam int unsigned STA_BUSY  = 0;
  localparam int unsigned STA_TAKEN = 1;
  localparam int unsigned STA_CYC   = 2;
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    BRANCH_UNSIGNED_GE    = 6'b000000, BRANCH_UNSIGNED_LT   = 6'b000001,
    BRANCH_NEGATIVE       = 6'b000010, BRANCH_NONNEGATIVE   = 6'b000011,
    BRANCH_SIGNED_GE      = 6'b000100, BRANCH_SIGNED_LT     = 6'b000101,
    BRANCH_HALFCARRY_HIGH = 6'b000110, BRANCH_HALFCARRY_LOW = 6'b000111,
    BRANCH_TFLAG_HIGH     = 6'b001000, BRANCH_TFLAG_LOW     = 6'b001001,
    BRANCH_OVERFLOW_HIGH  = 6'b001010, BRANCH_OVERFLOW_LOW  = 6'b001011,
    BRANCH_IRQ_ON         = 6'b001100, BRANCH_IRQ_OFF       = 6'b001101,
    IO_BIT_RAISE          = 6'b010000, IO_BIT_DROP          = 6'b010001,
    LOGICAL_LEFT_SHIFT    = 6'b010010, LOGICAL_RIGHT_SHIFT  = 6'b010011,
    ROTATE_LEFT_CARRY     = 6'b010100, ROTATE_RIGHT_CARRY   = 6'b010101,
    ARITH_RIGHT_SHIFT     = 6'b010110, NIBBLE_SWAP          = 6'b010111,
    INDEXED_FLAG_RAISE    = 6'b011000, INDEXED_FLAG_DROP    = 6'b011001,
    BIT_TO_TFLAG          = 6'b011010, TFLAG_TO_BIT         = 6'b011011,
    CARRY_RAISE           = 6'b100000, CARRY_DROP           = 6'b100001,
    ZERO_FLAG_RAISE       = 6'b100010, ZERO_FLAG_DROP       = 6'b100011,
    NEGATIVE_RAISE        = 6'b100100, NEGATIVE_DROP        = 6'b100101,
    OVERFLOW_RAISE        = 6'b100110, OVERFLOW_DROP        = 6'b100111,
    SIGN_FLAG_RAISE       = 6'b101000, SIGN_FLAG_DROP       = 6'b101001,
    HALFCARRY_RAISE       = 6'b101010, HALFCARRY_DROP       = 6'b101011,
    TFLAG_RAISE           = 6'b101100, TFLAG_DROP           = 6'b101101,
    IRQ_GLOBAL_ON         = 6'b101110, IRQ_GLOBAL_OFF       = 6'b101111
  } bbf_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_SECOND = 2'b10
  } bbf_state_t;

endpackage

// ==== core/bbf_brcond.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbf_brcond
  import bbf_pkg::*;
(
  input  wire logic [5:0] op,
  input  wire logic [7:0] flags,
  output logic            is_br,
  output logic            taken
);

  always_comb begin
    is_br = 1'b1;
    taken = 1'b0;
    unique case (op)
      BRANCH_UNSIGNED_GE:    taken = ~flags[FLG_C];
      BRANCH_UNSIGNED_LT:    taken = flags[FLG_C];
      BRANCH_NEGATIVE:       taken = flags[FLG_N];
      BRANCH_NONNEGATIVE:    taken = ~flags[FLG_N];
      BRANCH_SIGNED_GE:      taken = ~(flags[FLG_N] ^ flags[FLG_V]);
      BRANCH_SIGNED_LT:      taken = flags[FLG_N] ^ flags[FLG_V];
      BRANCH_HALFCARRY_HIGH: taken = flags[FLG_H];
      BRANCH_HALFCARRY_LOW:  taken = ~flags[FLG_H];
      BRANCH_TFLAG_HIGH:     taken = flags[FLG_T];
      BRANCH_TFLAG_LOW:      taken = ~flags[FLG_T];
      BRANCH_OVERFLOW_HIGH:  taken = flags[FLG_V];
      BRANCH_OVERFLOW_LOW:   taken = ~flags[FLG_V];
      BRANCH_IRQ_ON:         taken = flags[FLG_I];
      BRANCH_IRQ_OFF:        taken = ~flags[FLG_I];
      default:               is_br = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ==== core/bbf_bitops.sv ====
`timescale 1ns/1ps
`default_nettype none
module bbf_bitops
  import bbf_pkg::*;
(
  input  wire logic [5:0] op,
  input  wire logic [7:0] opnd,
  input  wire logic [2:0] sel,
  input  wire logic [7:0] flags,
  output logic      [7:0] res,
  output logic      [7:0] flags_n,
  output logic            wr_reg
);

  logic [7:0] sh;
  logic       sh_c;
  logic       is_sh;

  always_comb begin
    res     = opnd;
    flags_n = flags;
    wr_reg  = 1'b0;
    sh      = opnd;
    sh_c    = flags[FLG_C];
    is_sh   = 1'b0;
    unique case (op)
      LOGICAL_LEFT_SHIFT: begin
        sh    = {opnd[6:0], 1'b0};
        sh_c  = opnd[7];
        is_sh = 1'b1;
      end
      LOGICAL_RIGHT_SHIFT: begin
        sh    = {1'b0, opnd[7:1]};
        sh_c  = opnd[0];
        is_sh = 1'b1;
      end
      ROTATE_LEFT_CARRY: begin
        sh    = {opnd[6:0], flags[FLG_C]};
        sh_c  = opnd[7];
        is_sh = 1'b1;
      end
      ROTATE_RIGHT_CARRY: begin
        sh    = {flags[FLG_C], opnd[7:1]};
        sh_c  = opnd[0];
        is_sh = 1'b1;
      end
      ARITH_RIGHT_SHIFT: begin
        sh    = {opnd[7], opnd[7:1]};
        sh_c  = opnd[0];
        is_sh = 1'b1;
      end
      NIBBLE_SWAP: begin
        res    = {opnd[3:0], opnd[7:4]};
        wr_reg = 1'b1;
      end
      INDEXED_FLAG_RAISE: flags_n[sel] = 1'b1;
      INDEXED_FLAG_DROP:  flags_n[sel] = 1'b0;
      BIT_TO_TFLAG:       flags_n[FLG_T] = opnd[sel];
      TFLAG_TO_BIT: begin
        res[sel] = flags[FLG_T];
        wr_reg   = 1'b1;
      end
      // op[3:1] is the flag position, op[0] set means drop
      CARRY_RAISE, CARRY_DROP, ZERO_FLAG_RAISE, ZERO_FLAG_DROP,
      NEGATIVE_RAISE, NEGATIVE_DROP, OVERFLOW_RAISE, OVERFLOW_DROP,
      SIGN_FLAG_RAISE, SIGN_FLAG_DROP, HALFCARRY_RAISE, HALFCARRY_DROP,
      TFLAG_RAISE, TFLAG_DROP, IRQ_GLOBAL_ON, IRQ_GLOBAL_OFF:
        flags_n[op[3:1]] = ~op[0];
      default: wr_reg = 1'b0;
    endcase
    if (is_sh) begin
      res            = sh;
      wr_reg         = 1'b1;
      flags_n[FLG_C] = sh_c;
      flags_n[FLG_N] = sh[7];
      flags_n[FLG_V] = sh[7] ^ sh_c;
      flags_n[FLG_Z] = (sh == 8'h00);
    end
  end

endmodule
`default_nettype wire

// ==== core/bbf_exec.sv ====
// What this block does
// - carry clear/set branches go to pc+k+1; one cycle untaken, two taken
// - signed branches test N xor V: ge on 0, lt on 1
// - half-carry branches jump on H set or clear, flags untouched
// - T-flag branches jump on T set or clear; one or two cycles
// - overflow branches jump on V set or clear, flags untouched
// - interrupt branches jump on I set or clear
// - io bit raise sets one io register bit, others kept, two cycles
// - io bit drop clears one io register bit, others kept, two cycles
// - rotate left through carry, old bit 7 to carry, updates Z C N V
// - rotate right through carry, old bit 0 to carry, updates Z C N V
// - arithmetic right shift keeps bit 7, updates Z C N V, one cycle
// - bit to T copies chosen register bit into T only, one cycle
// - T to bit writes T into chosen register bit, flags kept
// - interrupt on and off set or clear I only, one cycle
// - overflow raise and drop force V only, one cycle
// - half-carry raise and drop force H only, one cycle
// - sign raise and drop force S only, one cycle
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bbf_exec
  import bbf_pkg::*;
#(
  parameter int unsigned PC_W = 11
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   exec_busy,
  output logic [7:0]             status_flags
);

  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
    $error("PC_W must lie between 8 and 16");
  end

  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic              aw_have_q, w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  bbf_state_t        state_q;
  logic              busy_q;
  logic [5:0]        op_q;
  logic [4:0]        rd_q, io_q, sel_q;
  logic [2:0]        bit_q;
  logic [K_W-1:0]    k_q;
  logic [7:0]        flags_q;
  logic [PC_W-1:0]   pc_q;
  logic              taken_q;
  logic [1:0]        cyc_q;
  logic [7:0]        rf [32];
  logic [7:0]        io_mem [32];

  // write path decode
  wire logic        wr_fire   = aw_have_q & w_have_q & ~bvalid_q;
  wire logic        idle      = (state_q == ST_IDLE);
  wire logic        a_cmd     = (awaddr_q == OFS_CMD);
  wire logic        a_flags   = (awaddr_q == OFS_FLAGS);
  wire logic        a_pc      = (awaddr_q == OFS_PC);
  wire logic        a_sel     = (awaddr_q == OFS_SEL);
  wire logic        a_reg     = (awaddr_q == OFS_REG);
  wire logic        a_io      = (awaddr_q == OFS_IO);
  wire logic        lane_ok   = a_cmd ? (&wstrb_q) :
                                a_pc  ? (&wstrb_q[1:0]) : wstrb_q[0];
  wire logic        busy_ok   = a_sel | (idle & (a_cmd | a_flags | a_pc |
                                                 a_reg | a_io));
  wire logic        sw_ok     = wr_fire & lane_ok & busy_ok;
  wire logic        start     = sw_ok & a_cmd;

  // read path decode
  wire logic [7:0]  ra        = s_axi_araddr;
  wire logic        r_map     = (ra == OFS_CMD) | (ra == OFS_FLAGS) |
                                (ra == OFS_PC) | (ra == OFS_STATUS) |
                                (ra == OFS_SEL) | (ra == OFS_REG) |
                                (ra == OFS_IO);
  wire logic [31:0] cmd_rd    = {6'h00, k_q, io_q, bit_q, rd_q, op_q};
  wire logic [31:0] sta_rd    = {28'h0000000, cyc_q, taken_q, busy_q};
  wire logic [31:0] r_mux     =
    (ra == OFS_CMD)    ? cmd_rd :
    (ra == OFS_FLAGS)  ? {24'h000000, flags_q} :
    (ra == OFS_PC)     ? {{(32-PC_W){1'b0}}, pc_q} :
    (ra == OFS_STATUS) ? sta_rd :
    (ra == OFS_SEL)    ? {27'h0000000, sel_q} :
    (ra == OFS_REG)    ? {24'h000000, rf[sel_q]} :
    (ra == OFS_IO)     ? {24'h000000, io_mem[sel_q]} : 32'h00000000;

  // execution datapath
  wire logic [7:0]  rd_val    = rf[rd_q];
  wire logic [7:0]  io_val    = io_mem[io_q];
  wire logic [7:0]  bit_mask  = 8'h01 << bit_q;
  wire logic        io_op     = (op_q == IO_BIT_RAISE) |
                                (op_q == IO_BIT_DROP);
  wire logic [7:0]  io_new    = (op_q == IO_BIT_RAISE) ?
                                (io_val | bit_mask) : (io_val & ~bit_mask);
  wire logic [PC_W-1:0] k_ext = {{(PC_W-K_W){k_q[K_W-1]}}, k_q};
  wire logic [PC_W-1:0] br_tgt = pc_q + k_ext + PC_W'(1);
  wire logic [PC_W-1:0] pc_inc = pc_q + PC_W'(1);
  logic             is_br, taken, wr_reg;
  logic [7:0]       alu_res, alu_flags;
  wire logic        two_cyc   = (is_br & taken) | io_op;
  wire logic        fin_one   = (state_q == ST_EXEC) & ~two_cyc;
  wire logic        fin_two   = (state_q == ST_SECOND);

  bbf_brcond u_brcond (
    .op    (op_q),
    .flags (flags_q),
    .is_br (is_br),
    .taken (taken)
  );

  bbf_bitops u_bitops (
    .op      (op_q),
    .opnd    (rd_val),
    .sel     (bit_q),
    .flags   (flags_q),
    .res     (alu_res),
    .flags_n (alu_flags),
    .wr_reg  (wr_reg)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign exec_busy     = busy_q;
  assign status_flags  = flags_q;

  // write address and data are taken in either order
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      if (bvalid_q && s_axi_bready) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // a refused or unmapped write answers slave error
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= sw_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= r_mux;
        rresp_q   <= r_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        arready_q <= 1'b1;
        rvalid_q  <= 1'b0;
      end
    end
  end

  // command sequencer; taken branches and io ops spend a second cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      taken_q <= 1'b0;
      cyc_q   <= 2'h0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          state_q <= ST_EXEC;
          busy_q  <= 1'b1;
        end
        ST_EXEC: begin
          taken_q <= is_br & taken;
          state_q <= two_cyc ? ST_SECOND : ST_IDLE;
          busy_q  <= two_cyc;
          cyc_q   <= two_cyc ? CYC_TWO : CYC_ONE;
        end
        ST_SECOND: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q  <= 6'h00;
      rd_q  <= 5'h00;
      bit_q <= 3'h0;
      io_q  <= 5'h00;
      k_q   <= '0;
      sel_q <= 5'h00;
    end else if (ce) begin
      if (start) begin
        op_q  <= wdata_q[CMD_OP_LSB +: 6];
        rd_q  <= wdata_q[CMD_RD_LSB +: 5];
        bit_q <= wdata_q[CMD_BIT_LSB +: 3];
        io_q  <= wdata_q[CMD_IO_LSB +: 5];
        k_q   <= wdata_q[CMD_K_LSB +: K_W];
      end
      if (sw_ok && a_sel) begin
        sel_q <= wdata_q[4:0];
      end
    end
  end

  // branches leave flags alone: alu_flags equals flags_q for them
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RST;
      pc_q    <= '0;
    end else if (ce) begin
      if (sw_ok && a_flags) begin
        flags_q <= wdata_q[7:0];
      end else if (fin_one) begin
        flags_q <= alu_flags;
      end
      if (sw_ok && a_pc) begin
        pc_q <= wdata_q[PC_W-1:0];
      end else if (fin_one || (fin_two && !is_br)) begin
        pc_q <= pc_inc;
      end else if (fin_two) begin
        pc_q <= br_tgt;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        rf[i]     <= 8'h00;
        io_mem[i] <= 8'h00;
      end
    end else if (ce) begin
      if (sw_ok && a_reg) begin
        rf[sel_q] <= wdata_q[7:0];
      end else if (fin_one && wr_reg) begin
        rf[rd_q] <= alu_res;
      end
      if (sw_ok && a_io) begin
        io_mem[sel_q] <= wdata_q[7:0];
      end else if (fin_two && io_op) begin
        io_mem[io_q] <= io_new;
      end
    end
  end

  default clocking cb @(posedge mclk iff ce);
  endclocking
  default disable iff (sys_rst);

  wire logic ex = (state_q == ST_EXEC);

  property p_br_untaken;
    ex && is_br && !taken |=> idle && pc_q == $past(pc_q) + 1'b1;
  endproperty
  a_br_untaken: assert property (p_br_untaken)
    else $error("untaken branch not done in one cycle");
  property p_br_taken;
    ex && is_br && taken |=> state_q == ST_SECOND ##1
      (idle && pc_q == $past(br_tgt, 2));
  endproperty
  a_br_taken: assert property (p_br_taken)
    else $error("taken branch target or timing wrong");
  property p_unsigned;
    ex && (op_q == BRANCH_UNSIGNED_GE || op_q == BRANCH_UNSIGNED_LT) |->
      taken == (flags_q[FLG_C] ^ (op_q == BRANCH_UNSIGNED_GE));
  endproperty
  a_unsigned: assert property (p_unsigned)
    else $error("carry branch decision wrong");
  property p_signed;
    ex && (op_q == BRANCH_SIGNED_GE || op_q == BRANCH_SIGNED_LT) |->
      taken == (flags_q[FLG_N] ^ flags_q[FLG_V] ^
                (op_q == BRANCH_SIGNED_GE));
  endproperty
  a_signed: assert property (p_signed)
    else $error("signed branch decision wrong");
  property p_flag_br;
    ex && is_br |-> taken == (op_q[0] ^ (
      (op_q[3:1] == 3'h1) ? flags_q[FLG_N] :
      (op_q[3:1] == 3'h3) ? flags_q[FLG_H] :
      (op_q[3:1] == 3'h4) ? flags_q[FLG_T] :
      (op_q[3:1] == 3'h5) ? flags_q[FLG_V] :
      (op_q[3:1] == 3'h6) ? flags_q[FLG_I] : taken ^ op_q[0]));
  endproperty
  a_flag_br: assert property (p_flag_br)
    else $error("single flag branch decision wrong");
  property p_br_keep;
    ex && is_br |=> $stable(flags_q);
  endproperty
  a_br_keep: assert property (p_br_keep)
    else $error("branch altered status flags");
  property p_io_bit;
    ex && io_op |=> state_q == ST_SECOND ##1 idle && io_mem[io_q] ==
      (($past(op_q, 2) == IO_BIT_RAISE) ? ($past(io_val, 2) | bit_mask)
                                        : ($past(io_val, 2) & ~bit_mask));
  endproperty
  a_io_bit: assert property (p_io_bit)
    else $error("io bit operation wrong");
  property p_rotate;
    ex && (op_q == ROTATE_LEFT_CARRY || op_q == ROTATE_RIGHT_CARRY) |=>
      rf[rd_q] == (($past(op_q) == ROTATE_LEFT_CARRY) ?
        {$past(rd_val[6:0]), $past(flags_q[FLG_C])} :
        {$past(flags_q[FLG_C]), $past(rd_val[7:1])}) && flags_q[FLG_C] ==
      (($past(op_q) == ROTATE_LEFT_CARRY) ? $past(rd_val[7])
                                          : $past(rd_val[0]));
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate through carry wrong");
  property p_arith_shift;
    ex && op_q == ARITH_RIGHT_SHIFT |=> idle &&
      rf[rd_q] == {$past(rd_val[7]), $past(rd_val[7:1])} &&
      flags_q[FLG_C] == $past(rd_val[0]);
  endproperty
  a_arith_shift: assert property (p_arith_shift)
    else $error("arithmetic shift wrong");
  property p_bit_to_t;
    ex && op_q == BIT_TO_TFLAG |=> flags_q[FLG_T] == $past(rd_val[bit_q])
      && flags_q[5:0] == $past(flags_q[5:0]) && $stable(flags_q[FLG_I]);
  endproperty
  a_bit_to_t: assert property (p_bit_to_t)
    else $error("bit to T copy wrong");
  property p_t_to_bit;
    ex && op_q == TFLAG_TO_BIT |=> rf[rd_q][bit_q] == $past(flags_q[FLG_T])
      && $stable(flags_q);
  endproperty
  a_t_to_bit: assert property (p_t_to_bit)
    else $error("T to bit load wrong");
  property p_flag_op;
    ex && op_q[5:4] == 2'b10 |=> idle && flags_q ==
      (($past(flags_q) & ~(8'h01 << $past(op_q[3:1]))) |
       ({7'h00, ~$past(op_q[0])} << $past(op_q[3:1])));
  endproperty
  a_flag_op: assert property (p_flag_op)
    else $error("dedicated flag operation wrong");
  property p_swap;
    ex && op_q == NIBBLE_SWAP |=> $stable(flags_q) &&
      rf[rd_q] == {$past(rd_val[3:0]), $past(rd_val[7:4])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

  c_taken: cover property (ex && is_br && taken ##2 idle);
  c_io:    cover property (ex && op_q == IO_BIT_RAISE ##2 idle);
  c_rotate: cover property (ex && op_q == ROTATE_LEFT_CARRY ##1 idle);

endmodule
`default_nettype wire

// ==== verification/bbf_exec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module branch_bit_flag_exec_tb_top
  import bbf_pkg::*;
;
  logic        mclk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, exec_busy, t;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, status_flags, f;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [39:0] tab [10];
  int          n_fail, compares, i, j;
  bbf_exec dut (.mclk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .exec_busy, .status_flags);
  task automatic summarize;
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int k);
    if (k == 40) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 40 && !s_axi_bvalid; k++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    tmo(k);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 40 && !s_axi_rvalid; k++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    tmo(k);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmd(input logic [5:0] o, input logic [2:0] b,
                     input logic [4:0] io, input logic [6:0] k);
    wr(OFS_CMD, {6'h00, k, io, b, 5'h03, o});
  endtask
  // expected branch outcome from the flags
  function automatic logic tk(input logic [5:0] o, input logic [7:0] g);
    logic [7:0] c;
    c = {1'b0, g[FLG_I], g[FLG_V], g[FLG_T], g[FLG_H],
         g[FLG_N] ^ g[FLG_V], g[FLG_N], g[FLG_C]};
    return c[o[3:1]] ^ o[0] ^ (o[3:1] == 3'h0 || o[3:1] == 3'h2);
  endfunction
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    // op, bit, flags in, register out, flags out
    tab = '{40'h1400010309, 40'h150001C005, 40'h160001C005, 40'h1200010209,
            40'h1300014009, 40'h1700011801, 40'h1A07008140, 40'h1B01408340,
            40'h1805008120, 40'h1900018100};
    {sys_rst, ce, s_axi_wstrb} = 6'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    chk({24'h0, status_flags}, {24'h0, FLAGS_RST});
    wr(OFS_SEL, 32'h3);
    for (j = 0; j < 3; j++)
      for (i = 0; i < 14; i++) begin
        f = j == 0 ? 8'h00 : j == 1 ? 8'hFF : 8'h55;
        t = tk(i[5:0], f);
        wr(OFS_FLAGS, {24'h0, f});
        wr(OFS_PC, 32'h20);
        cmd(i[5:0], 3'h0, 5'h00, 7'h7E);
        @(negedge mclk);
        chk({31'h0, exec_busy}, {31'h0, t});
        rd(OFS_PC, t?32'h1F:32'h21);
        rd(OFS_STATUS, {28'h0, t ? CYC_TWO : CYC_ONE, t, 1'b0});
        chk({24'h0, status_flags}, {24'h0, f});
      end
    foreach (tab[n]) begin
      wr(OFS_FLAGS, {24'h0, tab[n][23:16]});
      wr(OFS_REG, 32'h81);
      cmd(tab[n][37:32], tab[n][26:24], 5'h00, 7'h00);
      @(negedge mclk);
      chk({31'h0, exec_busy}, 32'h0);
      rd(OFS_REG, {24'h0, tab[n][15:8]});
      rd(OFS_FLAGS, {24'h0, tab[n][7:0]});
    end
    for (i = 0; i < 16; i++) begin
      wr(OFS_FLAGS, i[0] ? 32'hFF : 32'h00);
      cmd(6'h20 + i[5:0], 3'h0, 5'h00, 7'h00);
      f = 8'h01 << i[3:1];
      rd(OFS_FLAGS, {24'h0, i[0] ? ~f : f});
    end
    // an undefined code is a one-cycle no-op on the flags
    cmd(6'h3F, 3'h0, 5'h00, 7'h00);
    rd(OFS_FLAGS, 32'h7F);
    wr(OFS_IO, 32'h5A);
    cmd(IO_BIT_RAISE, 3'h0, 5'h03, 7'h00);
    @(negedge mclk);
    chk({31'h0, exec_busy}, 32'h1);
    rd(OFS_STATUS, {28'h0, CYC_TWO, 2'h0});
    cmd(IO_BIT_DROP, 3'h3, 5'h03, 7'h00);
    rd(OFS_IO, 32'h53);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, RESP_SLVERR);
    // a command word with missing lanes is refused and starts nothing
    s_axi_wstrb <= 4'h3;
    wr(OFS_CMD, 32'h0, RESP_SLVERR);
    s_axi_wstrb <= 4'hF;
    rd(OFS_STATUS, {28'h0, CYC_TWO, 2'h0});
    summarize();
  end
endmodule
`default_nettype wire
